// ---- logic/core_status_option_irq_regs.sv ----
// Core status, option, interrupt control and peripheral enable registers
`timescale 1ns/1ns
// Overview of operation
// - Flag-updating ops block data write to flags
// - Timeout and sleep flags ignore writes
// - Bank pair selects 128-byte direct bank
// - Subtract adds complement; carry means no borrow
// - Timeout flag set by power-up, clear, sleep
// - Sleep flag cleared by sleep op
// - Zero flag follows zero result
// - Digit flag is carry from bit three
// - Carry flag is carry from top bit
// - Rotates load carry with shifted-out bit
// - Pull-ups on when option bit low
// - External edge chosen by polarity bit
// - Timer source and edge selectable
// - Prescaler goes to watchdog or timer
// - Ratio decodes to 2^(n+1) or 2^n
// - Flags set regardless of enables
// - Global gate blocks or passes interrupts
// - Peripheral gate blocks converter interrupt
// - Timer, pin edge, pin change set flags
// - Only converter enable bit is implemented
// - Per-source enables gate their flags
// - Converter done sets sticky flag
module core_status_option_irq_regs
  import core_regs_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input reg_access_type regAccess,
  input alu_req_type aluRequest,
  input wire logic watchdogClearOp,
  input wire logic sleepOp,
  input wire logic watchdogTimeout,
  input wire logic instrCycleTick,
  input wire logic watchdogBaseTick,
  input wire logic sharedPin,
  input wire logic [2:0] portPins,
  input wire logic adcDone,
  input wire logic [6:0] directOffset,
  output logic [7:0] regReadData,
  output logic [8:0] mappedAddr,
  output logic indirectBank,
  output logic [2:0] pullupEnable,
  output logic [7:0] timer0Count,
  output logic watchdogTick,
  output logic irqRequest
);

  logic [7:0] statusReg;
  logic [7:0] optionReg;
  logic [7:0] intCtlReg;
  logic adcEnable;
  logic adcFlag;
  logic pinPrev;
  logic [2:0] portPrev;
  alu_flags_type aluFlags;
  logic statusWrite;
  logic optionWrite;
  logic intCtlWrite;
  logic periphEnWrite;
  logic periphFlagWrite;
  logic extEdge;
  logic timerPinEdge;
  logic timerSource;
  logic timerTick;
  logic timerOverflow;
  logic pinChange;
  logic historyValid;
  logic pinRise;
  logic pinFall;
  logic prescaleIn;
  logic prescaleOut;
  logic [3:0] prescaleExp;
  logic [7:0] next_status;
  logic [7:0] next_intCtl;

  if (PRESCALE_WIDTH < 8)
  begin : g_width_check
    $error("PRESCALE_WIDTH must be at least 8");
  end

  // Both bank aliases reach the same register
  function automatic logic is_addr(input logic [7:0] addr, input logic [7:0] a,
                                   input logic [7:0] b);
    is_addr = (addr == a) || (addr == b);
  endfunction : is_addr

  function automatic logic [8:0] bank_address(input logic [1:0] bank,
                                              input logic [6:0] offset);
    bank_address = 9'(bank * BANK_BYTES) + {2'b00, offset};
  endfunction : bank_address

  alu_flag_calc flagCalc (
    .request(aluRequest),
    .carryIn(statusReg[ST_CARRY]),
    .flags(aluFlags)
  );

  assign statusWrite = regAccess.write && is_addr(regAccess.addr, STATUS_ADDR, STATUS_ALT_ADDR);
  assign intCtlWrite = regAccess.write && is_addr(regAccess.addr, INTCTL_ADDR, INTCTL_ALT_ADDR);
  assign optionWrite = regAccess.write && (regAccess.addr == OPTION_ADDR);
  assign periphEnWrite = regAccess.write && (regAccess.addr == PERIPH_EN_ADDR);
  assign periphFlagWrite = regAccess.write && (regAccess.addr == PERIPH_FLAG_ADDR);

  // Status register next value
  always_comb
  begin
    next_status = statusReg;
    if (statusWrite)
    begin
      next_status[ST_INDIRECT] = regAccess.data[ST_INDIRECT];
      next_status[ST_BANK_HI] = regAccess.data[ST_BANK_HI];
      next_status[ST_BANK_LO] = regAccess.data[ST_BANK_LO];
    end
    if (statusWrite && !(aluFlags.updZero || aluFlags.updDigit || aluFlags.updCarry))
    begin
      next_status[ST_ZERO] = regAccess.data[ST_ZERO];
      next_status[ST_DIGIT] = regAccess.data[ST_DIGIT];
      next_status[ST_CARRY] = regAccess.data[ST_CARRY];
    end
    if (aluFlags.updZero)
      next_status[ST_ZERO] = aluFlags.zero;
    if (aluFlags.updDigit)
      next_status[ST_DIGIT] = aluFlags.digit;
    if (aluFlags.updCarry)
      next_status[ST_CARRY] = aluFlags.carry;
    if (watchdogClearOp || sleepOp)
      next_status[ST_WDOG] = 1'b1;
    else if (watchdogTimeout)
      next_status[ST_WDOG] = 1'b0;
    if (sleepOp)
      next_status[ST_SLEEP] = 1'b0;
    else if (watchdogClearOp)
      next_status[ST_SLEEP] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      statusReg <= STATUS_RESET;
    else
      statusReg <= next_status;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      optionReg <= OPTION_RESET;
    else if (optionWrite)
      optionReg <= regAccess.data;
  end

  // Pin history for edge and change detection; the first sample after
  // reset only primes it, so a pin idling high raises no false edge
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinPrev <= 1'b0;
      portPrev <= 3'b000;
      historyValid <= 1'b0;
    end
    else
    begin
      pinPrev <= sharedPin;
      portPrev <= portPins;
      historyValid <= 1'b1;
    end
  end

  // Edges are only trusted once the history holds a real sample
  assign pinRise = historyValid && sharedPin && !pinPrev;
  assign pinFall = historyValid && !sharedPin && pinPrev;

  assign extEdge = optionReg[OPT_POLARITY] ? pinRise : pinFall;

  assign timerPinEdge = optionReg[OPT_EDGE] ? pinFall : pinRise;
  assign timerSource = optionReg[OPT_SRC] ? timerPinEdge : instrCycleTick;

  assign pinChange = historyValid && (portPins != portPrev);

  assign prescaleIn = optionReg[OPT_ASSIGN] ? watchdogBaseTick : timerSource;

  assign prescaleExp = optionReg[OPT_ASSIGN]
    ? {1'b0, optionReg[OPT_RATIO_LSB +: 3]}
    : {1'b0, optionReg[OPT_RATIO_LSB +: 3]} + 4'h1;

  // Reassigning the prescaler restarts it so no stale count leaks across
  ratio_divider #(
    .WIDTH(PRESCALE_WIDTH)
  ) prescaler (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .clear(optionWrite),
    .tickIn(prescaleIn),
    .exponent(prescaleExp),
    .tickOut(prescaleOut)
  );

  // Timer runs 1:1 when prescaler serves watchdog
  assign timerTick = optionReg[OPT_ASSIGN] ? timerSource : prescaleOut;
  assign timerOverflow = timerTick && (timer0Count == TIMER_MAX);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      timer0Count <= 8'h00;
    else if (timerTick)
      timer0Count <= timer0Count + 8'h01;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      watchdogTick <= 1'b0;
    else
      watchdogTick <= optionReg[OPT_ASSIGN] ? prescaleOut : watchdogBaseTick;
  end

  // Interrupt control next value; a set in the clearing cycle wins
  always_comb
  begin
    next_intCtl = intCtlWrite ? regAccess.data : intCtlReg;
    if (timerOverflow)
      next_intCtl[IC_TMR_FLAG] = 1'b1;
    if (extEdge)
      next_intCtl[IC_EXT_FLAG] = 1'b1;
    if (pinChange)
      next_intCtl[IC_PIN_CHG_FLAG] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      intCtlReg <= INTCTL_RESET;
    else
      intCtlReg <= next_intCtl;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      adcEnable <= PERIPH_RESET[PERIPH_ADC];
    else if (periphEnWrite)
      adcEnable <= regAccess.data[PERIPH_ADC];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      adcFlag <= PERIPH_RESET[PERIPH_ADC];
    else if (adcDone)
      adcFlag <= 1'b1;
    else if (periphFlagWrite)
      adcFlag <= regAccess.data[PERIPH_ADC];
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irqRequest <= 1'b0;
    else
      irqRequest <= intCtlReg[IC_GLOBAL] &&
        ((intCtlReg[IC_TMR_EN] && intCtlReg[IC_TMR_FLAG]) ||
         (intCtlReg[IC_EXT_EN] && intCtlReg[IC_EXT_FLAG]) ||
         (intCtlReg[IC_PIN_CHG_EN] && intCtlReg[IC_PIN_CHG_FLAG]) ||
         (intCtlReg[IC_PERIPH] && adcEnable && adcFlag));
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      pullupEnable <= 3'b000;
    else
      pullupEnable <= {3{!optionReg[OPT_PULLUP_N]}};
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mappedAddr <= 9'h000;
      indirectBank <= 1'b0;
    end
    else
    begin
      mappedAddr <= bank_address(statusReg[ST_BANK_HI:ST_BANK_LO], directOffset);
      indirectBank <= statusReg[ST_INDIRECT];
    end
  end

  // Registered read; unmapped addresses and unimplemented bits read zero
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      regReadData <= 8'h00;
    else if (is_addr(regAccess.addr, STATUS_ADDR, STATUS_ALT_ADDR))
      regReadData <= statusReg;
    else if (is_addr(regAccess.addr, INTCTL_ADDR, INTCTL_ALT_ADDR))
      regReadData <= intCtlReg;
    else if (regAccess.addr == OPTION_ADDR)
      regReadData <= optionReg;
    else if (regAccess.addr == PERIPH_EN_ADDR)
      regReadData <= 8'(adcEnable) << PERIPH_ADC;
    else if (regAccess.addr == PERIPH_FLAG_ADDR)
      regReadData <= 8'(adcFlag) << PERIPH_ADC;
    else
      regReadData <= 8'h00;
  end

endmodule : core_status_option_irq_regs

// ---- logic/core_regs_pkg.sv ----
// Constants and carrier types for the core status, option and interrupt registers
package core_regs_pkg;

  // Register addresses as seen by the instruction datapath
  localparam logic [7:0] STATUS_ADDR = 8'h03;
  localparam logic [7:0] STATUS_ALT_ADDR = 8'h83;
  localparam logic [7:0] INTCTL_ADDR = 8'h0B;
  localparam logic [7:0] INTCTL_ALT_ADDR = 8'h8B;
  localparam logic [7:0] PERIPH_FLAG_ADDR = 8'h0C;
  localparam logic [7:0] OPTION_ADDR = 8'h81;
  localparam logic [7:0] PERIPH_EN_ADDR = 8'h8C;

  // Reset values; unknown arithmetic flags come up as zero
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
  localparam logic [7:0] PERIPH_RESET = 8'h00;

  // Status register field positions
  localparam int ST_CARRY = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_WDOG = 4;
  localparam int ST_BANK_LO = 5;
  localparam int ST_BANK_HI = 6;
  localparam int ST_INDIRECT = 7;

  // Option register field positions
  localparam int OPT_RATIO_LSB = 0;
  localparam int OPT_ASSIGN = 3;
  localparam int OPT_EDGE = 4;
  localparam int OPT_SRC = 5;
  localparam int OPT_POLARITY = 6;
  localparam int OPT_PULLUP_N = 7;

  // Interrupt control field positions
  localparam int IC_PIN_CHG_FLAG = 0;
  localparam int IC_EXT_FLAG = 1;
  localparam int IC_TMR_FLAG = 2;
  localparam int IC_PIN_CHG_EN = 3;
  localparam int IC_EXT_EN = 4;
  localparam int IC_TMR_EN = 5;
  localparam int IC_PERIPH = 6;
  localparam int IC_GLOBAL = 7;

  // Peripheral enable and flag field position
  localparam int PERIPH_ADC = 6;

  // Direct bank size in bytes and timer wrap value
  localparam int BANK_BYTES = 128;
  localparam logic [7:0] TIMER_MAX = 8'hFF;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_ADD = 3'b001,
    OP_SUB = 3'b010,
    OP_ROTL = 3'b011,
    OP_ROTR = 3'b100,
    OP_LOGIC = 3'b101
  } alu_kind_type;

  typedef struct packed {
    alu_kind_type kind;
    logic [7:0] operandA;
    logic [7:0] operandB;
  } alu_req_type;

  typedef struct packed {
    logic zero;
    logic digit;
    logic carry;
    logic updZero;
    logic updDigit;
    logic updCarry;
  } alu_flags_type;

  typedef struct packed {
    logic write;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_access_type;

endpackage : core_regs_pkg

// ---- logic/alu_flag_calc.sv ----
// Arithmetic flag computation for add, subtract, rotate and logic results
`timescale 1ns/1ns
module alu_flag_calc
  import core_regs_pkg::*;
(
  input alu_req_type request,
  input logic carryIn,
  output alu_flags_type flags
);

  logic [8:0] sum;
  logic [4:0] lowSum;

  always_comb
  begin
    sum = 9'h000;
    lowSum = 5'h00;
    flags = '0;
    unique case (request.kind)
      OP_ADD:
      begin
        sum = {1'b0, request.operandA} + {1'b0, request.operandB};
        lowSum = {1'b0, request.operandA[3:0]} + {1'b0, request.operandB[3:0]};
        flags = '{zero: (sum[7:0] == 8'h00), digit: lowSum[4], carry: sum[8],
                  updZero: 1'b1, updDigit: 1'b1, updCarry: 1'b1};
      end
      OP_SUB:
      begin
        sum = {1'b0, request.operandA} + {1'b0, ~request.operandB} + 9'h001;
        lowSum = {1'b0, request.operandA[3:0]} + {1'b0, ~request.operandB[3:0]} + 5'h01;
        flags = '{zero: (sum[7:0] == 8'h00), digit: lowSum[4], carry: sum[8],
                  updZero: 1'b1, updDigit: 1'b1, updCarry: 1'b1};
      end
      OP_ROTL:
      begin
        flags = '{zero: 1'b0, digit: 1'b0, carry: request.operandA[7],
                  updZero: 1'b0, updDigit: 1'b0, updCarry: 1'b1};
      end
      OP_ROTR:
      begin
        flags = '{zero: 1'b0, digit: 1'b0, carry: request.operandA[0],
                  updZero: 1'b0, updDigit: 1'b0, updCarry: 1'b1};
      end
      OP_LOGIC:
      begin
        flags = '{zero: (request.operandA == 8'h00), digit: 1'b0, carry: carryIn,
                  updZero: 1'b1, updDigit: 1'b0, updCarry: 1'b0};
      end
      OP_NONE:
      begin
        flags = '0;
      end
      default:
      begin
        flags = '0;
      end
    endcase
  end

endmodule : alu_flag_calc

// ---- logic/ratio_divider.sv ----
// Shared binary prescaler with a selectable power-of-two ratio
`timescale 1ns/1ns
module ratio_divider
  import core_regs_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic tickIn,
  input wire logic [3:0] exponent,
  output logic tickOut
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] mask;

  // Elaboration check: the top ratio needs eight counter bits
  if (WIDTH < 8)
  begin : g_width_check
    $error("ratio_divider needs at least 8 bits for 1:256");
  end

  // A ratio of 2^k fires when the low k bits are all ones
  assign mask = WIDTH'((1 << exponent) - 1);
  assign tickOut = tickIn && ((count & mask) == mask);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (tickIn)
      count <= count + WIDTH'(1);
  end

endmodule : ratio_divider

// ---- sim/flag_model.svh ----
// Expected add and subtract flags packed as zero, digit, carry
function automatic logic [2:0] add_sub_flags(input logic sub, input logic [7:0] a,
  input logic [7:0] b);
  logic [8:0] s;
  logic [4:0] n;
  s = sub ? {1'b0, a} + {1'b0, ~b} + 9'h001 : {1'b0, a} + {1'b0, b};
  n = sub ? {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01 : {1'b0, a[3:0]} + {1'b0, b[3:0]};
  return {s[7:0] == 8'h00, n[4], s[8]};
endfunction : add_sub_flags

// ---- sim/core_status_option_irq_regs_chk.sv ----
// Port-level assertions for the core status, option and interrupt registers
`timescale 1ns/1ns
module core_status_option_irq_regs_chk
  import core_regs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input reg_access_type regAccess,
  input alu_req_type aluRequest,
  input wire logic watchdogClearOp,
  input wire logic sleepOp,
  input wire logic watchdogTimeout,
  input wire logic [6:0] directOffset,
  input logic [7:0] regReadData,
  input logic [8:0] mappedAddr,
  input logic indirectBank,
  input logic [2:0] pullupEnable,
  input logic irqRequest
);
  `include "flag_model.svh"
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  property p_pullup;
    regAccess.write && regAccess.addr == OPTION_ADDR |=> ##1
      pullupEnable == {3{~$past(regAccess.data[OPT_PULLUP_N], 2)}};
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up enables wrong");

  property p_periph_zero;
    regAccess.addr == PERIPH_EN_ADDR || regAccess.addr == PERIPH_FLAG_ADDR |=>
      (regReadData & 8'hBF) == 8'h00;
  endproperty
  a_periph_zero: assert property (p_periph_zero) else $error("unused bits set");

  property p_gate_off;
    regAccess.addr == INTCTL_ADDR ##1 !regReadData[IC_GLOBAL] |-> !irqRequest;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("request while gated");

  property p_gate_on;
    regAccess.addr == INTCTL_ADDR ##1
      (regReadData[IC_GLOBAL] && |(regReadData[5:3] & regReadData[2:0])) |-> irqRequest;
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("request missing");

  property p_bank_map;
    regAccess.addr == STATUS_ADDR |=> indirectBank == regReadData[ST_INDIRECT] &&
      mappedAddr == {regReadData[ST_BANK_HI:ST_BANK_LO], $past(directOffset)};
  endproperty
  a_bank_map: assert property (p_bank_map) else $error("bank mapping wrong");

  property p_sleep;
    sleepOp && !watchdogClearOp ##1 regAccess.addr == STATUS_ADDR |=>
      regReadData[ST_WDOG:ST_SLEEP] == 2'b10;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");

  property p_timeout;
    watchdogTimeout && !watchdogClearOp && !sleepOp ##1 regAccess.addr == STATUS_ADDR
      |=> !regReadData[ST_WDOG];
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag wrong");

  property p_clear;
    watchdogClearOp ##1 regAccess.addr == STATUS_ADDR |=>
      regReadData[ST_WDOG:ST_SLEEP] == 2'b11;
  endproperty
  a_clear: assert property (p_clear) else $error("clear flags wrong");

  property p_add_sub;
    aluRequest.kind inside {OP_ADD, OP_SUB} ##1 regAccess.addr == STATUS_ADDR |=>
      regReadData[2:0] == add_sub_flags($past(aluRequest.kind, 2) == OP_SUB,
      $past(aluRequest.operandA, 2), $past(aluRequest.operandB, 2));
  endproperty
  a_add_sub: assert property (p_add_sub) else $error("add flags wrong");

  property p_rotate;
    aluRequest.kind inside {OP_ROTL, OP_ROTR} ##1 regAccess.addr == STATUS_ADDR |=>
      regReadData[ST_CARRY] == ($past(aluRequest.kind, 2) == OP_ROTL ?
      $past(aluRequest.operandA[7], 2) : $past(aluRequest.operandA[0], 2));
  endproperty
  a_rotate: assert property (p_rotate) else $error("rotate carry wrong");
endmodule : core_status_option_irq_regs_chk

bind core_status_option_irq_regs core_status_option_irq_regs_chk u_core_status_option_irq_regs_chk
(
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .regAccess(regAccess),
  .aluRequest(aluRequest),
  .watchdogClearOp(watchdogClearOp),
  .sleepOp(sleepOp),
  .watchdogTimeout(watchdogTimeout),
  .directOffset(directOffset),
  .regReadData(regReadData),
  .mappedAddr(mappedAddr),
  .indirectBank(indirectBank),
  .pullupEnable(pullupEnable),
  .irqRequest(irqRequest)
);

// ---- sim/periph_model.sv ----
// Stand-in for timer pin, port pins, converter and tick sources
`timescale 1ns/1ns
module periph_model
(
  input wire logic sys_clk,
  input wire logic reset_n,
  output logic instrCycleTick,
  output logic watchdogBaseTick,
  output logic sharedPin,
  output logic [2:0] portPins,
  output logic adcDone
);
  logic [1:0] phase;
  initial
  begin
    sharedPin = 1'b0;
    portPins = 3'b000;
    adcDone = 1'b0;
  end
  // Ticks free-run from a phase that reset clears, so prescaler phase is fixed relative to the bench
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase <= 2'b00;
    else
      phase <= phase + 2'b01;
  end
  assign instrCycleTick = (phase == 2'b11);
  assign watchdogBaseTick = phase[0];
  // Pin held two clocks per level, slower than the edge detector
  task pin_pulses(input int n);
    repeat (2 * n)
    begin
      repeat (2) @(posedge sys_clk);
      #1;
      sharedPin = ~sharedPin;
    end
  endtask : pin_pulses
  task port_set(input logic [2:0] v);
    @(posedge sys_clk);
    #1;
    portPins = v;
  endtask : port_set
  task adc_fire;
    @(posedge sys_clk);
    #1;
    adcDone = 1'b1;
    @(posedge sys_clk);
    #1;
    adcDone = 1'b0;
  endtask : adc_fire
endmodule : periph_model

// ---- sim/core_status_option_irq_regs_bench.sv ----
// Self-checking bench for the core status, option and interrupt registers
`timescale 1ns/1ns
module core_status_option_irq_regs_bench
  import core_regs_pkg::*;
;
  `include "flag_model.svh"
  localparam alu_req_type NO_ALU = '{OP_NONE, 8'h00, 8'h00};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  reg_access_type regAccess = '{1'b0, 8'h00, 8'h00};
  alu_req_type aluRequest = NO_ALU;
  logic watchdogClearOp = 1'b0;
  logic sleepOp = 1'b0;
  logic watchdogTimeout = 1'b0;
  logic [6:0] directOffset = 7'h00;
  logic instrCycleTick, watchdogBaseTick, sharedPin, adcDone, indirectBank, irqRequest;
  logic watchdogTick;
  logic [2:0] portPins, pullupEnable;
  logic [7:0] regReadData, timer0Count, a, b, d;
  logic [8:0] mappedAddr;
  logic [2:0] f;
  logic [15:0] note;
  logic [15:0] notes[$];
  int rdCount = 0;
  int rdSeen = 0;
  logic markDly = 1'b0;
  int n_errors = 0;
  int checked = 0;
  int ticks;
  int wdTicks = 0;
  alu_kind_type kind;

  always #4 sys_clk = ~sys_clk;

  core_status_option_irq_regs #(.PRESCALE_WIDTH(8)) u_core_status_option_irq_regs
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .regAccess(regAccess), .aluRequest(aluRequest),
    .watchdogClearOp(watchdogClearOp), .sleepOp(sleepOp), .watchdogTimeout(watchdogTimeout),
    .instrCycleTick(instrCycleTick), .watchdogBaseTick(watchdogBaseTick),
    .sharedPin(sharedPin), .portPins(portPins), .adcDone(adcDone),
    .directOffset(directOffset), .regReadData(regReadData), .mappedAddr(mappedAddr),
    .indirectBank(indirectBank), .pullupEnable(pullupEnable), .timer0Count(timer0Count),
    .watchdogTick(watchdogTick), .irqRequest(irqRequest)
  );
  periph_model u_periph_model
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .instrCycleTick(instrCycleTick),
    .watchdogBaseTick(watchdogBaseTick), .sharedPin(sharedPin), .portPins(portPins),
    .adcDone(adcDone)
  );

  task chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    checked++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      n_errors++;
    end
  endtask : chk
  task results;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  // One datapath cycle; each call sets the access, ALU request, event and offset inputs, which then hold until the next call
  task cyc(input logic w, input logic [7:0] ad, input logic [7:0] dt, input alu_req_type q,
    input logic [2:0] ev, input logic rd, input logic [7:0] ex, input logic [7:0] m);
    @(posedge sys_clk);
    #1;
    regAccess = '{w, ad, dt};
    aluRequest = q;
    {watchdogClearOp, sleepOp, watchdogTimeout} = ev;
    directOffset = 7'($urandom);
    if (rd)
    begin
      rdCount++;
      notes.push_back({ex, m});
    end
  endtask : cyc
  task wr(input logic [7:0] ad, input logic [7:0] dt);
    cyc(1'b1, ad, dt, NO_ALU, 3'b000, 1'b0, 8'h00, 8'h00);
  endtask : wr
  task rdc(input logic [7:0] ad, input logic [7:0] ex, input logic [7:0] m);
    cyc(1'b0, ad, 8'h00, NO_ALU, 3'b000, 1'b1, ex, m);
  endtask : rdc

  // Read results land one clock after the address
  // A new read is seen by its count, so idle stretches raise no check
  always @(posedge sys_clk)
  begin
    markDly <= (rdCount != rdSeen);
    rdSeen <= rdCount;
  end
  always @(negedge sys_clk)
  begin
    if (markDly)
    begin
      if (notes.size() == 0)
        chk("read note", 8'h00, 8'hFF);
      else
      begin
        note = notes.pop_front();
        chk("regReadData", note[15:8] & note[7:0], regReadData & note[7:0]);
      end
    end
  end

  initial
  begin
    ticks = $urandom(32'h312B);
    repeat (3) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    rdc(STATUS_ADDR, STATUS_RESET, 8'hFF);
    rdc(OPTION_ADDR, OPTION_RESET, 8'hFF);
    rdc(INTCTL_ADDR, INTCTL_RESET, 8'hFF);
    rdc(PERIPH_EN_ADDR, PERIPH_RESET, 8'hFF);
    rdc(8'h20, 8'h00, 8'hFF);
    // Timer stays on the idle pin at 1:1 so the pin section can predict its count
    d = 8'($urandom) | 8'h28;
    wr(OPTION_ADDR, d);
    rdc(OPTION_ADDR, d, 8'hFF);
    wr(PERIPH_EN_ADDR, 8'hFF);
    rdc(PERIPH_EN_ADDR, 8'h40, 8'hFF);
    wr(INTCTL_ADDR, 8'h78);
    rdc(INTCTL_ADDR, 8'h78, 8'hFF);
    // Bank bit follows status writes; timeout and sleep flags keep their reset value
    wr(STATUS_ADDR, 8'h20);
    rdc(STATUS_ADDR, 8'h38, 8'hFF);
    wr(STATUS_ADDR, 8'h00);
    rdc(STATUS_ADDR, 8'h18, 8'hFF);
    // Same-cycle status write must lose to the flag update
    for (int i = 0; i < 15; i++)
    begin
      kind = alu_kind_type'(3'(1 + i % 5));
      a = (i < 5) ? 8'h80 : 8'($urandom);
      b = (i < 5) ? 8'h80 : 8'($urandom);
      case (kind)
        OP_ADD: f = add_sub_flags(1'b0, a, b);
        OP_SUB: f = add_sub_flags(1'b1, a, b);
        OP_ROTL: f = {2'b00, a[7]};
        OP_ROTR: f = {2'b00, a[0]};
        default: f = {a == 8'h00, 2'b00};
      endcase
      d = (kind inside {OP_ROTL, OP_ROTR}) ? 8'hF9 : (kind == OP_LOGIC) ? 8'hFC : 8'hFF;
      cyc(1'b1, STATUS_ADDR, 8'h07, '{kind, a, b}, 3'b000, 1'b0, 8'h00, 8'h00);
      rdc(STATUS_ADDR, {5'b00011, f}, d);
    end
    for (int i = 0; i < 3; i++)
    begin
      cyc(1'b0, 8'h20, 8'h00, NO_ALU, 3'b001 << ((4 - i) % 3), 1'b0, 8'h00, 8'h00);
      rdc(STATUS_ADDR, (i == 0) ? 8'h10 : (i == 1) ? 8'h00 : 8'h18, 8'hF8);
    end
    u_periph_model.port_set(3'b101);
    u_periph_model.pin_pulses(256);
    rdc(INTCTL_ADDR, 8'h7F, 8'hFF);
    chk("timer0Count", 8'h00, timer0Count);
    u_periph_model.adc_fire();
    rdc(PERIPH_FLAG_ADDR, 8'h40, 8'hFF);
    wr(OPTION_ADDR, 8'hC0);
    rdc(8'h20, 8'h00, 8'hFF);
    ticks = 0;
    // Ticks are looked at mid-cycle, where the next edge will take them
    for (int k = 0; k < 400 && ticks < 40; k++)
    begin
      @(negedge sys_clk);
      if (ticks > 0 && watchdogTick === 1'b1)
        wdTicks++;
      if (instrCycleTick === 1'b1)
        ticks++;
    end
    if (ticks < 40)
      n_errors++;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("timer0Count", 8'h14, timer0Count);
    chk("watchdogTick", 8'h4E, 8'(wdTicks));
    for (int i = 0; i < 4; i++)
    begin
      d = (i == 0) ? 8'hBF : (i == 1) ? 8'h3F : (i == 2) ? 8'hC0 : 8'h80;
      wr(INTCTL_ADDR, d);
      rdc(INTCTL_ADDR, d, 8'hFF);
      rdc(8'h20, 8'h00, 8'hFF);
      chk("irqRequest", {7'h00, i[0] == 1'b0}, {7'h00, irqRequest});
    end
    wr(INTCTL_ADDR, 8'h00);
    rdc(INTCTL_ADDR, 8'h00, 8'hFF);
    rdc(8'h20, 8'h00, 8'hFF);
    repeat (2) @(negedge sys_clk);
    results();
  end
endmodule : core_status_option_irq_regs_bench
